// File: rtl/mpc_pkg.sv
// Purpose : Shared constants of the monitor pin control block.
// Assumes : 40 MHz core clock.
// Notes   : Bit positions refer to the bit vectors presented on the ports.
package mpc_pkg;

    // ==========================================================
    // Clock and timing
    localparam int unsigned CLK_HZ        = 40000000;
    localparam int unsigned PULSE_MIN_MS  = 10;
    localparam int unsigned PULSE_CYCLES  = (CLK_HZ / 1000) * PULSE_MIN_MS;
    localparam int unsigned PULSE_CW      = 19;

    // ==========================================================
    // Configuration register bit positions
    localparam int unsigned CFG_ALERT_EN  = 1;
    localparam int unsigned CFG_RST_EN    = 4;
    localparam int unsigned CFG_ALT_MODE  = 5;

    // ==========================================================
    // Mask register one and fan divisor register bit positions
    localparam int unsigned MASK1_CHAIN   = 7;
    localparam int unsigned FDIV_RST_EN   = 7;
    localparam int unsigned FDIV_OS_SEL   = 6;

    // ==========================================================
    // Reset values
    localparam logic [7:0]  CFG_RESET     = 8'h00;
    localparam logic [7:0]  MASK1_RESET   = 8'h00;
    localparam logic [7:0]  FDIV_RESET    = 8'h00;

endpackage

// File: rtl/mpc_pulse_timer.sv
// Purpose : Minimum-width pulse stretcher for open-drain low pulses.
// Assumes : Single clock; start is a one-cycle request.
// Notes   : Pulse lasts exactly CYCLES clock cycles; a start while busy restarts it.
`timescale 1ns/1ps
`default_nettype none
module mpc_pulse_timer
    import mpc_pkg::*;
#(
    parameter int unsigned CYCLES = PULSE_CYCLES
) (
    // Clock and reset
    input  wire logic clk,
    input  wire logic resetn,
    // Control
    input  wire logic start,
    output logic      active
);
    logic [PULSE_CW-1:0] cnt_ff;
    logic [PULSE_CW-1:0] nxt_cnt;

    // ==========================================================
    // Counter
    always_comb begin
        nxt_cnt = cnt_ff;
        if (start) begin
            nxt_cnt = PULSE_CW'(CYCLES);
        end else if (cnt_ff != '0) begin
            nxt_cnt = cnt_ff - PULSE_CW'(1);
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            cnt_ff <= '0;
        end else begin
            cnt_ff <= nxt_cnt;
        end
    end

    assign active = (cnt_ff != '0);

    pulse_len_a: assert property (@(posedge clk) disable iff (!resetn)
        (start ##1 !start [*7]) |-> active)
        else $error("pulse ended too early");

endmodule
`default_nettype wire

// File: rtl/mpc_top.sv
// Behaviour
// - Alert asserts when any monitored value exceeds its limit, if enabled.
// - Active-low chain input reaches alert via mask one bit 7 and config bit 1.
// - Alert driven only while config bit 1 is one; disabled after reset.
// - Config bit 5 picks open-source non-maskable or open-drain request style.
// - Enclosure line is active-high input; bit 5 pulls it low at least 10 ms.
// - Board heat input state is reported as an interrupt status bit.
// - Power switch output is active-low open-drain under software control.
// - System reset output is an active-low pulse of at least 10 ms.
// - Reset output usable only when config bit 4 and divisor bit 7 set.
// - Divisor bit 6 turns the shared pin into active-low overheat shutdown.
// - Low test-select input enters connectivity tree test mode.
// - During tree test mode the alert, enclosure, heat, power and reset outputs are held low.
// - Address low bit from low strap pin, top two bits from upper straps.
// - In tree test mode the low strap pin outputs the test result.
//
// Purpose : Pin-level control of a serial-bus hardware monitor.
// Assumes : Register contents arrive as plain ports from the register file.
// Notes   : Pins from outside pass two flip-flops; open-drain pins use oe high = drive.
`timescale 1ns/1ps
`default_nettype none
module mpc_top
    import mpc_pkg::*;
#(
    parameter int unsigned PULSE_LEN = PULSE_CYCLES
) (
    // Clock and reset
    input  wire logic       clk,
    input  wire logic       resetn,
    // Register contents
    input  wire logic [7:0] config_reg,
    input  wire logic [7:0] mask1_reg,
    input  wire logic [7:0] fan_div_reg,
    // Internal events
    input  wire logic       limit_exceeded,
    input  wire logic       overtemp_event,
    input  wire logic       reset_request,
    input  wire logic       enclosure_clear_req,
    input  wire logic       power_switch_on,
    input  wire logic       tree_result_in,
    // Alert pin and chain input
    input  wire logic       alert_chain_n,
    output logic            alert_out,
    output logic            alert_oe,
    // Enclosure line
    input  wire logic       enclosure_open_line_in,
    output logic            enclosure_open_line_out,
    output logic            enclosure_open_line_oe,
    output logic            enclosure_open,
    // Board heat
    input  wire logic       board_heat_alert,
    output logic            board_heat_status,
    // Power switch
    output logic            power_switch_drive_out,
    output logic            power_switch_drive_oe,
    // Reset or overheat shutdown pin
    output logic            reset_pin_out,
    output logic            reset_pin_oe,
    output logic            overheat_shutdown,
    // Test and address straps
    input  wire logic       tree_test_select_n,
    input  wire logic       bus_address_lsb_in,
    output logic            bus_address_lsb_out,
    output logic            bus_address_lsb_oe,
    input  wire logic [1:0] bus_address_upper,
    output logic [2:0]      bus_address,
    output logic            tree_test_mode,
    output logic            logic_resetn
);
    // ==========================================================
    // Input synchronisers
    localparam int unsigned NSYNC = 7;
    // Idle pin levels, so that no false intrusion or chain alert shows after reset
    localparam logic [NSYNC-1:0] SYNC_IDLE = 7'h7d;
    logic [NSYNC-1:0] raw_in;
    logic [NSYNC-1:0] s1_ff;
    logic [NSYNC-1:0] s2_ff;

    assign raw_in = {bus_address_upper, bus_address_lsb_in, tree_test_select_n,
                     board_heat_alert, enclosure_open_line_in, alert_chain_n};

    genvar gi;
    generate
        for (gi = 0; gi < NSYNC; gi++) begin : g_sync
            always_ff @(posedge clk or negedge resetn) begin
                if (!resetn) begin
                    s1_ff[gi] <= SYNC_IDLE[gi];
                    s2_ff[gi] <= SYNC_IDLE[gi];
                end else begin
                    s1_ff[gi] <= raw_in[gi];
                    s2_ff[gi] <= s1_ff[gi];
                end
            end
        end
    endgenerate

    logic chain_n_s;
    logic encl_s;
    logic heat_s;
    logic test_n_s;
    logic lsb_s;
    logic [1:0] upper_s;
    assign chain_n_s = s2_ff[0];
    assign encl_s    = s2_ff[1];
    assign heat_s    = s2_ff[2];
    assign test_n_s  = s2_ff[3];
    assign lsb_s     = s2_ff[4];
    assign upper_s   = s2_ff[6:5];

    // ==========================================================
    // Tree test mode and internal reset
    logic test_ff;
    logic nxt_test;
    logic run;

    always_comb begin
        nxt_test = !test_n_s;
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            test_ff <= 1'b0;
        end else begin
            test_ff <= nxt_test;
        end
    end

    // Functional outputs are forced to reset values while testing; the pulse timers keep counting
    assign run = !test_ff;

    // ==========================================================
    // Pulse timers for enclosure clear and system reset
    logic encl_start;
    logic rst_start;
    logic encl_active;
    logic rst_active;
    logic rst_allowed;
    logic os_mode;

    assign rst_allowed = config_reg[CFG_RST_EN] && fan_div_reg[FDIV_RST_EN];
    assign os_mode     = fan_div_reg[FDIV_OS_SEL];
    // Clear only under bit 5 control
    assign encl_start  = run && enclosure_clear_req && config_reg[CFG_ALT_MODE];
    assign rst_start   = run && reset_request && rst_allowed && !os_mode;

    mpc_pulse_timer #(.CYCLES(PULSE_LEN)) u_encl_timer (
        .clk    (clk),
        .resetn (resetn),
        .start  (encl_start),
        .active (encl_active)
    );

    mpc_pulse_timer #(.CYCLES(PULSE_LEN)) u_rst_timer (
        .clk    (clk),
        .resetn (resetn),
        .start  (rst_start),
        .active (rst_active)
    );

    // ==========================================================
    // Output stage, all registered
    logic       nxt_alert_out;
    logic       nxt_alert_oe;
    logic       nxt_encl_oe;
    logic       nxt_encl;
    logic       nxt_heat;
    logic       nxt_psw_oe;
    logic       nxt_rst_oe;
    logic       nxt_os;
    logic       nxt_lsb_out;
    logic       nxt_lsb_oe;
    logic [2:0] nxt_addr;
    logic       nxt_strap_hold;
    logic       alert_cause;

    logic       alert_out_ff;
    logic       alert_oe_ff;
    logic       encl_oe_ff;
    logic       encl_ff;
    logic       heat_ff;
    logic       psw_oe_ff;
    logic       rst_oe_ff;
    logic       os_ff;
    logic       lsb_out_ff;
    logic       lsb_oe_ff;
    logic [2:0] addr_ff;
    logic       strap_hold_ff;
    logic       test_out_ff;

    always_comb begin
        alert_cause = limit_exceeded
                    || (mask1_reg[MASK1_CHAIN] && !chain_n_s);
        nxt_alert_out = 1'b0;
        nxt_alert_oe  = 1'b0;
        if (run && config_reg[CFG_ALERT_EN] && alert_cause) begin
            if (config_reg[CFG_ALT_MODE]) begin
                // Open-source: drive high while active
                nxt_alert_out = 1'b1;
                nxt_alert_oe  = 1'b1;
            end else begin
                // Open-drain: pull low while active
                nxt_alert_out = 1'b0;
                nxt_alert_oe  = 1'b1;
            end
        end
        nxt_encl_oe = run && encl_active;
        nxt_encl    = run && encl_s;
        nxt_heat    = run && !heat_s;
        nxt_psw_oe  = run && power_switch_on;
        nxt_os      = run && os_mode && overtemp_event;
        nxt_rst_oe  = run && (os_mode ? overtemp_event : rst_active);
        // Straps are frozen while the pin serves as the test output, and for
        // one cycle after, while the pin's own drive is still in the first synchroniser stage
        nxt_strap_hold = lsb_oe_ff;
        nxt_addr    = (test_ff || lsb_oe_ff || strap_hold_ff) ? addr_ff
                    : {upper_s, lsb_s};
        nxt_lsb_oe  = test_ff;
        nxt_lsb_out = test_ff && tree_result_in;
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            alert_out_ff <= 1'b0;
            alert_oe_ff  <= 1'b0;
            encl_oe_ff   <= 1'b0;
            encl_ff      <= 1'b0;
            heat_ff      <= 1'b0;
            psw_oe_ff    <= 1'b0;
            rst_oe_ff    <= 1'b0;
            os_ff        <= 1'b0;
            lsb_out_ff   <= 1'b0;
            lsb_oe_ff    <= 1'b0;
            addr_ff      <= 3'h0;
            strap_hold_ff <= 1'b0;
            test_out_ff  <= 1'b0;
        end else begin
            alert_out_ff <= nxt_alert_out;
            alert_oe_ff  <= nxt_alert_oe;
            encl_oe_ff   <= nxt_encl_oe;
            encl_ff      <= nxt_encl;
            heat_ff      <= nxt_heat;
            psw_oe_ff    <= nxt_psw_oe;
            rst_oe_ff    <= nxt_rst_oe;
            os_ff        <= nxt_os;
            lsb_out_ff   <= nxt_lsb_out;
            lsb_oe_ff    <= nxt_lsb_oe;
            addr_ff      <= nxt_addr;
            strap_hold_ff <= nxt_strap_hold;
            test_out_ff  <= test_ff;
        end
    end

    assign alert_out               = alert_out_ff;
    assign alert_oe                = alert_oe_ff;
    assign enclosure_open_line_out = 1'b0;
    assign enclosure_open_line_oe  = encl_oe_ff;
    assign enclosure_open          = encl_ff;
    assign board_heat_status       = heat_ff;
    assign power_switch_drive_out  = 1'b0;
    assign power_switch_drive_oe   = psw_oe_ff;
    assign reset_pin_out           = 1'b0;
    assign reset_pin_oe            = rst_oe_ff;
    assign overheat_shutdown       = os_ff;
    assign bus_address_lsb_out     = lsb_out_ff;
    assign bus_address_lsb_oe      = lsb_oe_ff;
    assign bus_address             = addr_ff;
    assign tree_test_mode          = test_out_ff;
    assign logic_resetn            = !test_out_ff;

    // ==========================================================
    // Checks
    alert_gate_a: assert property (@(posedge clk) disable iff (!resetn)
        !config_reg[CFG_ALERT_EN] |=> !alert_oe)
        else $error("alert driven while disabled");

    alert_limit_a: assert property (@(posedge clk) disable iff (!resetn)
        (run && config_reg[CFG_ALERT_EN] && limit_exceeded) |=> alert_oe)
        else $error("alert missing on limit");

    alert_style_a: assert property (@(posedge clk) disable iff (!resetn)
        alert_oe |-> (alert_out == $past(config_reg[CFG_ALT_MODE])))
        else $error("alert style wrong");

    chain_pass_a: assert property (@(posedge clk) disable iff (!resetn)
        (run && !chain_n_s && mask1_reg[MASK1_CHAIN] && config_reg[CFG_ALERT_EN])
        |=> alert_oe)
        else $error("chain input not passed");

    rst_enable_a: assert property (@(posedge clk) disable iff (!resetn)
        $rose(rst_active) |-> $past(rst_allowed))
        else $error("reset pulse without enable");

    rst_width_a: assert property (@(posedge clk) disable iff (!resetn)
        (rst_start && run && !os_mode) |=> ##1 reset_pin_oe [*4])
        else $error("reset pulse too short");

    test_hold_a: assert property (@(posedge clk) disable iff (!resetn)
        test_ff |=> (!alert_oe && !power_switch_drive_oe && lsb_oe_ff))
        else $error("logic active during tree test");

    test_entry_a: assert property (@(posedge clk) disable iff (!resetn)
        !test_n_s |=> ##1 bus_address_lsb_oe)
        else $error("tree test not entered");

    heat_report_a: assert property (@(posedge clk) disable iff (!resetn)
        (run && !heat_s) |=> board_heat_status)
        else $error("board heat not reported");

    encl_clear_a: assert property (@(posedge clk) disable iff (!resetn)
        encl_start |=> ##1 enclosure_open_line_oe)
        else $error("enclosure clear not driven");

endmodule
`default_nettype wire

// File: verification/mpc_board_model.sv
// Purpose : Board-side circuits around the pin control block.
// Assumes : Enclosure latch is set by a switch and cleared by a held low pull.
// Notes   : Heat sensor is open drain with a pull-up, so idle reads high.
`timescale 1ns/1ps
`default_nettype none
module mpc_board_model #(
    parameter int unsigned CLEAR_CYCLES = 8
) (
    // Clock
    input  wire logic clk,
    // Stimulus
    input  wire logic intrusion_event,
    input  wire logic heat_assert,
    // Pins
    input  wire logic line_oe,
    output logic      line_level,
    output logic      heat_n
);
    // ==========================================================
    // Enclosure latch
    logic        latch = 1'b0;
    int unsigned low_cnt = 0;

    // A short pull must not clear the latch, so the hold time is counted
    always @(posedge clk) begin
        low_cnt <= line_oe ? low_cnt + 1 : 0;
        if (intrusion_event) begin
            latch <= 1'b1;
        end else if (line_oe && (low_cnt + 1 >= CLEAR_CYCLES)) begin
            latch <= 1'b0;
        end
    end

    assign line_level = latch & ~line_oe;
    assign heat_n     = ~heat_assert;
endmodule
`default_nettype wire

// File: verification/tb.sv
// Purpose : Self-checking bench of the monitor pin control block.
// Assumes : Short pulse length so timed pulses can be counted whole.
// Notes   : Inputs change by non-blocking assignment on the rising edge.
`timescale 1ns/1ps
`default_nettype none
module tb;
    import mpc_pkg::*;
    localparam int unsigned PLEN = 8;
    logic       clk = 1'b0, resetn = 1'b0;
    logic [7:0] cfg = 8'h00, msk = 8'h00, fdiv = 8'h00;
    logic       lim = 1'b0, ovt = 1'b0, rreq = 1'b0, creq = 1'b0, pwr = 1'b0;
    logic       tres = 1'b0, chain_n = 1'b1, test_n = 1'b1, strap_lsb = 1'b1;
    logic       intr = 1'b0, heat = 1'b0;
    logic [1:0] strap_up = 2'h2;
    int         miscompares = 0, check_count = 0;
    wire logic  alert_out, alert_oe, encl_in, encl_out, encl_oe, enclosure_open;
    wire logic  heat_n, heat_status, psw_out, psw_oe, rst_out, rst_oe, os_out;
    wire logic  lsb_in, lsb_out, lsb_oe, test_mode, logic_resetn;
    wire logic [2:0] bus_address;
    wire logic [1:0] pulse_view = {rst_oe, encl_oe};

    // The strap pin reads the block's own drive while it is enabled
    assign lsb_in = lsb_oe ? lsb_out : strap_lsb;

    initial forever #12.5 clk = ~clk;

    mpc_top #(.PULSE_LEN(PLEN)) mpc_top_inst (
        .clk(clk), .resetn(resetn), .config_reg(cfg), .mask1_reg(msk),
        .fan_div_reg(fdiv), .limit_exceeded(lim), .overtemp_event(ovt),
        .reset_request(rreq), .enclosure_clear_req(creq), .power_switch_on(pwr),
        .tree_result_in(tres), .alert_chain_n(chain_n), .alert_out(alert_out),
        .alert_oe(alert_oe), .enclosure_open_line_in(encl_in),
        .enclosure_open_line_out(encl_out), .enclosure_open_line_oe(encl_oe),
        .enclosure_open(enclosure_open), .board_heat_alert(heat_n),
        .board_heat_status(heat_status), .power_switch_drive_out(psw_out),
        .power_switch_drive_oe(psw_oe), .reset_pin_out(rst_out),
        .reset_pin_oe(rst_oe), .overheat_shutdown(os_out),
        .tree_test_select_n(test_n), .bus_address_lsb_in(lsb_in),
        .bus_address_lsb_out(lsb_out), .bus_address_lsb_oe(lsb_oe),
        .bus_address_upper(strap_up), .bus_address(bus_address),
        .tree_test_mode(test_mode), .logic_resetn(logic_resetn));

    mpc_board_model #(.CLEAR_CYCLES(PLEN)) mpc_board_model_inst (
        .clk(clk), .intrusion_event(intr), .heat_assert(heat),
        .line_oe(encl_oe), .line_level(encl_in), .heat_n(heat_n));

    // ==========================================================
    // Shared tasks
    task automatic check(input string name, input logic [7:0] exp, input logic [7:0] got);
        check_count++;
        if (got !== exp) begin
            miscompares++;
            $display("Error %s expected %h seen %h", name, exp, got);
        end
    endtask

    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
        @(negedge clk);
    endtask

    // One-cycle request, then the driven cycles of the matching pin are counted
    task automatic pulse_req(input int idx, output int n);
        @(posedge clk);
        if (idx == 1) rreq <= 1'b1; else creq <= 1'b1;
        @(posedge clk);
        rreq <= 1'b0;
        creq <= 1'b0;
        n = 0;
        repeat (3 * PLEN) begin
            @(negedge clk);
            if (pulse_view[idx] === 1'b1) n++;
        end
    endtask

    task automatic close_out;
        if (miscompares == 0 && check_count > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    initial begin
        repeat (20000) @(posedge clk);
        miscompares++;
        close_out;
    end

    // ==========================================================
    // Main sequence
    initial begin
        int n;
        repeat (5) @(posedge clk);
        resetn <= 1'b1;
        cyc(4);
        check("alert_oe", 8'h00, alert_oe);
        check("bus_address", {5'h00, strap_up, strap_lsb}, bus_address);
        @(posedge clk); lim <= 1'b1;
        cyc(2); check("alert_oe", 8'h00, alert_oe);
        @(posedge clk); cfg <= 8'h02;
        cyc(2); check("alert_oe", 8'h01, alert_oe);
        check("alert_out", 8'h00, alert_out);
        @(posedge clk); cfg <= 8'h22;
        cyc(2); check("alert_out", 8'h01, alert_out);
        @(posedge clk); lim <= 1'b0; chain_n <= 1'b0;
        cyc(4); check("alert_oe", 8'h00, alert_oe);
        @(posedge clk); cfg <= 8'h00; msk <= 8'h80;
        @(posedge clk); cfg <= 8'h22;
        cyc(2); check("alert_oe", 8'h01, alert_oe);
        @(posedge clk); chain_n <= 1'b1;
        cyc(4); check("alert_oe", 8'h00, alert_oe);
        @(posedge clk); intr <= 1'b1; cfg <= 8'h02;
        @(posedge clk); intr <= 1'b0;
        cyc(4); check("enclosure_open", 8'h01, enclosure_open);
        pulse_req(0, n); check("clear_len", 8'h00, n[7:0]);
        @(posedge clk); cfg <= 8'h22;
        pulse_req(0, n); check("clear_len", PLEN[7:0], n[7:0]);
        check("enclosure_open", 8'h00, enclosure_open);
        check("enclosure_line_out", 8'h00, encl_out);
        @(posedge clk); heat <= 1'b1; pwr <= 1'b1;
        cyc(4); check("heat_status", 8'h01, heat_status);
        check("power_oe", 8'h01, psw_oe);
        check("power_out", 8'h00, psw_out);
        @(posedge clk); heat <= 1'b0; pwr <= 1'b0;
        cyc(4); check("heat_status", 8'h00, heat_status);
        check("power_oe", 8'h00, psw_oe);
        @(posedge clk); cfg <= 8'h10;
        pulse_req(1, n); check("reset_len", 8'h00, n[7:0]);
        @(posedge clk); fdiv <= 8'h80;
        pulse_req(1, n); check("reset_len", PLEN[7:0], n[7:0]);
        check("reset_out", 8'h00, rst_out);
        @(posedge clk); fdiv <= 8'hc0; ovt <= 1'b1;
        cyc(2); check("overheat", 8'h01, os_out);
        check("reset_oe", 8'h01, rst_oe);
        @(posedge clk); ovt <= 1'b0;
        cyc(2); check("overheat", 8'h00, os_out);
        check("reset_oe", 8'h00, rst_oe);
        @(posedge clk); cfg <= 8'h02; lim <= 1'b1; tres <= 1'b1; test_n <= 1'b0;
        cyc(4); check("test_mode", 8'h01, test_mode);
        check("logic_resetn", 8'h00, logic_resetn);
        check("alert_oe", 8'h00, alert_oe);
        check("lsb_oe", 8'h01, lsb_oe);
        check("lsb_out", 8'h01, lsb_out);
        @(posedge clk); tres <= 1'b0;
        cyc(2); check("lsb_out", 8'h00, lsb_out);
        @(posedge clk); test_n <= 1'b1;
        cyc(4); check("test_mode", 8'h00, test_mode);
        check("logic_resetn", 8'h01, logic_resetn);
        check("lsb_oe", 8'h00, lsb_oe);
        check("bus_address", {5'h00, strap_up, strap_lsb}, bus_address);
        cyc(1); check("bus_address", {5'h00, strap_up, strap_lsb}, bus_address);
        close_out;
    end
endmodule
`default_nettype wire
